// ### logic/link_sup_params.svh
// Offsets, field positions, reset values and timing counts for the link supervisor
`ifndef LINK_SUP_PARAMS_SVH
`define LINK_SUP_PARAMS_SVH
// Register byte offsets
`define SUP_CFG_OFF       8'h00
`define SUP_GAP_OFF       8'h04
`define SUP_PING_INT_OFF  8'h08
`define SUP_PING_REG_OFF  8'h0c
`define SUP_CTRL_OFF      8'h10
`define SUP_STAT_OFF      8'h14
`define SUP_IRQ_ST_OFF    8'h18
`define SUP_IRQ_MASK_OFF  8'h1c
// Configuration word fields
`define SUP_CFG_ID_LSB    0
`define SUP_CFG_RTRY_LSB  8
`define SUP_CFG_PREAD_BIT 12
`define SUP_CFG_CEN_BIT   13
`define SUP_CFG_SEN_BIT   14
`define SUP_CFG_ETH_BIT   15
// Reset values
`define SUP_CFG_RST       16'h0301
`define SUP_GAP_RST       16'h000a
`define SUP_PING_INT_RST  16'h03e8
`define SUP_PING_REG_RST  16'h0000
`define SUP_CTRL_RST      16'h0000
// Interrupt status bits
`define SUP_IRQ_FAIL_BIT  0
`define SUP_IRQ_CHG_BIT   1
// Modbus codes used for link tests
`define SUP_FN_ECHO       8'h08
`define SUP_FN_ECHO_SUB   16'h0000
`define SUP_FN_READ       8'h03
`define SUP_ETH_ID        8'h01
// Timing
`define SUP_CLK_HZ        10000000
`define SUP_MS_PER_S      1000
`define SUP_MS_CYCLES     (`SUP_CLK_HZ / `SUP_MS_PER_S)
`define SUP_TIMEOUT_MS    100
`endif

// ### logic/link_sup_pkg.sv
// Types shared by the link supervisor
package link_sup_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_GAP  = 5'b00010,
        ST_SEND = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_DONE = 5'b10000
    } fsm_e;
    typedef enum logic [1:0] {OP_INACTIVE = 2'h0, OP_STANDBY = 2'h1, OP_ACTIVE = 2'h2} op_e;
    typedef enum logic [1:0] {KIND_ECHO = 2'h0, KIND_READ = 2'h1, KIND_POLL = 2'h2} kind_e;
    typedef enum logic [1:0] {CODE_OK = 2'h0, CODE_UNAVAIL = 2'h1, CODE_FAIL = 2'h2, CODE_SLVERR = 2'h3} code_e;
endpackage

// ### logic/modbus_slave_link_supervisor.sv
// Per-slave link supervisor of a Modbus master with a classic Wishbone register port
//
// Function
// R01 - Every request carries the configured station identity, which must be distinct per master.
// R02 - An Ethernet slave gets one point-to-point exchange at a time and identity 0 is replaced by 1.
// R03 - A failed exchange is retried up to the retry count and only then declared a failure.
// R04 - Successive messages to the slave are separated by at least the minimum gap in ms.
// R05 - Link tests in standby are spaced by the ping repeat interval.
// R06 - Echo pinging sends function 08 sub-function 0 and the slave echoes it.
// R07 - Register pinging reads the configured register and the value is discarded.
// R08 - With control enabled the operating state comes from the control value, else the slave is active.
// R09 - With reporting enabled the link status code is written out to the application.
// R10 - Control 0 is inactive, 1 is standby (ping only), 2 is active (poll).
// R11 - Any other control value selects inactive.
// R12 - Status 0 means responding normally or set inactive.
// R13 - Status 1 means a standby ping failed, or the master is faulted, initialising or inactive.
// R14 - Status 2 means polled but not responding.
// R15 - Status 3 means the slave reports illegal requested values.
// R16 - An exchange with no valid reply within the response timeout is a failed attempt.
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "link_sup_params.svh"

module modbus_slave_link_supervisor #(
    parameter int MS_CYCLES  = `SUP_MS_CYCLES,
    parameter int TIMEOUT_MS = `SUP_TIMEOUT_MS
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       req_valid,
    output link_sup_pkg::kind_e        req_kind,
    output logic      [7:0]            req_station,
    output logic      [7:0]            req_func,
    output logic      [15:0]           req_word,
    input  wire logic                  resp_valid,
    input  wire logic                  resp_ok,
    input  wire logic                  resp_exc,
    input  wire logic                  master_fault,
    output logic                       stat_wr,
    output link_sup_pkg::code_e        stat_value,
    output logic                       irq
);
    import link_sup_pkg::*;

    // Refuse timings that do not fit the 16-bit counters
    if (MS_CYCLES < 1 || MS_CYCLES > 65535 || TIMEOUT_MS < 1 || TIMEOUT_MS > 65535) begin : g_bad_timing
        $error("modbus_slave_link_supervisor: timing parameter out of range");
    end

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
    localparam logic [15:0] TMO_MS  = 16'(TIMEOUT_MS);

    logic [15:0] cfg;
    logic [15:0] gap_ms;
    logic [15:0] ping_int;
    logic [15:0] ping_reg;
    logic [15:0] ctrl;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    fsm_e        fsm;
    op_e         op_state;
    code_e       link_code;
    code_e       report;
    logic [15:0] ms_pre;
    logic        ms_tick;
    logic [15:0] ms_cnt;
    logic [15:0] wait_ms;
    logic [3:0]  attempts;
    logic [3:0]  max_tries;
    logic [7:0]  eff_id;
    logic        wb_req;
    logic        wb_wr;
    logic        wb_rd;
    logic        resp_take;
    logic        timeout;
    logic        fail_evt;
    logic [1:0]  irq_set;
    logic        report_en;

    // Decoded configuration
    assign report_en = cfg[`SUP_CFG_SEN_BIT];
    assign max_tries = (cfg[`SUP_CFG_RTRY_LSB +: 4] == 4'h0) ? 4'h1 : cfg[`SUP_CFG_RTRY_LSB +: 4];

    // Ethernet links are point to point, so an unset identity falls back to the usual 1
    always_comb begin
        eff_id = cfg[`SUP_CFG_ID_LSB +: 8];                                  // see R01
        if (cfg[`SUP_CFG_ETH_BIT] && eff_id == 8'h00) begin
            eff_id = `SUP_ETH_ID;                                            // see R02
        end
    end

    // Operating state from the control value; unknown codes fall to inactive
    always_comb begin
        if (!cfg[`SUP_CFG_CEN_BIT]) begin
            op_state = OP_ACTIVE;                                            // see R08
        end else if (ctrl == 16'h0001) begin
            op_state = OP_STANDBY;                                           // see R10
        end else if (ctrl == 16'h0002) begin
            op_state = OP_ACTIVE;                                            // see R10
        end else begin
            op_state = OP_INACTIVE;                                          // see R11
        end
    end

    // Spacing before the next message: standby honours both the gap and the ping interval
    always_comb begin
        wait_ms = gap_ms;                                                    // see R04
        if (op_state == OP_STANDBY && ping_int > gap_ms) begin
            wait_ms = ping_int;                                              // see R05
        end
    end

    // Wishbone strobes
    assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr     = wb_req && wb_we_i;
    assign wb_rd     = wb_req && !wb_we_i;
    assign resp_take = resp_valid && fsm == ST_WAIT;
    assign timeout   = fsm == ST_WAIT && ms_tick && ms_cnt == 16'h0000 && !resp_valid;  // see R16
    assign fail_evt  = timeout && attempts + 4'h1 >= max_tries;            // see R03

    // Bus answer: one wait state, unmapped addresses read zero and ignore writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_rd) begin
                if (wb_adr_i == `SUP_CFG_OFF) begin
                    wb_dat_o <= {16'h0000, cfg};
                end else if (wb_adr_i == `SUP_GAP_OFF) begin
                    wb_dat_o <= {16'h0000, gap_ms};
                end else if (wb_adr_i == `SUP_PING_INT_OFF) begin
                    wb_dat_o <= {16'h0000, ping_int};
                end else if (wb_adr_i == `SUP_PING_REG_OFF) begin
                    wb_dat_o <= {16'h0000, ping_reg};
                end else if (wb_adr_i == `SUP_CTRL_OFF) begin
                    wb_dat_o <= {16'h0000, ctrl};
                end else if (wb_adr_i == `SUP_STAT_OFF) begin
                    wb_dat_o <= {21'h000000, fsm, attempts, link_code};
                end else if (wb_adr_i == `SUP_IRQ_ST_OFF) begin
                    wb_dat_o <= {30'h00000000, irq_st};
                end else if (wb_adr_i == `SUP_IRQ_MASK_OFF) begin
                    wb_dat_o <= {30'h00000000, irq_mask};
                end
            end
        end
    end

    // Writable registers, byte lanes 0 and 1 only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg      <= `SUP_CFG_RST;
            gap_ms   <= `SUP_GAP_RST;
            ping_int <= `SUP_PING_INT_RST;
            ping_reg <= `SUP_PING_REG_RST;
            ctrl     <= `SUP_CTRL_RST;
            irq_mask <= 2'h0;
        end else if (ce && wb_wr) begin
            if (wb_adr_i == `SUP_CFG_OFF) begin
                if (wb_sel_i[0]) cfg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) cfg[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `SUP_GAP_OFF) begin
                if (wb_sel_i[0]) gap_ms[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) gap_ms[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `SUP_PING_INT_OFF) begin
                if (wb_sel_i[0]) ping_int[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ping_int[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `SUP_PING_REG_OFF) begin
                if (wb_sel_i[0]) ping_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ping_reg[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `SUP_CTRL_OFF) begin
                if (wb_sel_i[0]) ctrl[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ctrl[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `SUP_IRQ_MASK_OFF) begin
                if (wb_sel_i[0]) irq_mask <= wb_dat_i[1:0];
            end
        end
    end

    // Sticky events; a read clears them, but an event in the same cycle survives
    always_comb begin
        irq_set = 2'h0;
        irq_set[`SUP_IRQ_FAIL_BIT] = fail_evt;
        irq_set[`SUP_IRQ_CHG_BIT]  = report != link_code;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_st <= 2'h0;
            irq    <= 1'b0;
        end else if (ce) begin
            if (wb_rd && wb_adr_i == `SUP_IRQ_ST_OFF) begin
                irq_st <= irq_set;
            end else begin
                irq_st <= irq_st | irq_set;
            end
            // Follow the value being loaded, so a clearing read drops irq together with the bit
            irq <= |(((wb_rd && wb_adr_i == `SUP_IRQ_ST_OFF) ? irq_set : (irq_st | irq_set)) & irq_mask);
        end
    end

    // Millisecond prescaler, restarted whenever a new wait is loaded
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ms_pre <= 16'h0000;
        end else if (ce) begin
            if (fsm == ST_IDLE || fsm == ST_SEND || fsm == ST_DONE || ms_tick) begin
                ms_pre <= 16'h0000;
            end else begin
                ms_pre <= ms_pre + 16'h0001;
            end
        end
    end
    assign ms_tick = ms_pre == MS_LAST;

    // Exchange sequencer: gap, send, wait for reply or timeout, then settle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fsm      <= ST_IDLE;
            ms_cnt   <= 16'h0000;
            attempts <= 4'h0;
        end else if (ce) begin
            if (op_state == OP_INACTIVE || master_fault) begin
                fsm      <= ST_IDLE;                                         // see R10
                attempts <= 4'h0;
            end else begin
                case (fsm)
                    ST_IDLE: begin
                        fsm    <= ST_GAP;
                        ms_cnt <= wait_ms;                                   // see R04
                    end
                    ST_GAP: begin
                        if (ms_cnt == 16'h0000) begin
                            fsm <= ST_SEND;
                        end else if (ms_tick) begin
                            ms_cnt <= ms_cnt - 16'h0001;
                        end
                    end
                    ST_SEND: begin
                        fsm    <= ST_WAIT;
                        ms_cnt <= TMO_MS - 16'h0001;                         // see R16
                    end
                    ST_WAIT: begin
                        if (resp_valid) begin
                            fsm      <= ST_DONE;
                            attempts <= 4'h0;
                        end else if (timeout) begin
                            fsm      <= ST_DONE;
                            attempts <= fail_evt ? 4'h0 : attempts + 4'h1;   // see R03
                        end else if (ms_tick) begin
                            ms_cnt <= ms_cnt - 16'h0001;
                        end
                    end
                    ST_DONE: begin
                        fsm    <= ST_GAP;
                        ms_cnt <= wait_ms;                                   // see R04
                    end
                    default: begin
                        fsm <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Request out: a single one-cycle pulse, so an Ethernet link never sees overlap
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_valid   <= 1'b0;
            req_kind    <= KIND_ECHO;
            req_station <= 8'h00;
            req_func    <= 8'h00;
            req_word    <= 16'h0000;
        end else if (ce) begin
            req_valid <= 1'b0;
            if (fsm == ST_SEND && op_state != OP_INACTIVE && !master_fault) begin
                req_valid   <= 1'b1;                                         // see R02
                req_station <= eff_id;                                       // see R01
                if (op_state == OP_ACTIVE) begin
                    req_kind <= KIND_POLL;                                   // see R10
                    req_func <= 8'h00;
                    req_word <= 16'h0000;
                end else if (cfg[`SUP_CFG_PREAD_BIT]) begin
                    req_kind <= KIND_READ;                                   // see R07
                    req_func <= `SUP_FN_READ;
                    req_word <= ping_reg;
                end else begin
                    req_kind <= KIND_ECHO;                                   // see R06
                    req_func <= `SUP_FN_ECHO;
                    req_word <= `SUP_FN_ECHO_SUB;
                end
            end
        end
    end

    // Link status; read data of a register ping is never kept
    always_comb begin
        report = link_code;
        if (master_fault) begin
            report = CODE_UNAVAIL;                                           // see R13
        end else if (op_state == OP_INACTIVE) begin
            report = CODE_OK;                                                // see R12
        end else if (resp_take && resp_exc) begin
            report = CODE_SLVERR;                                            // see R15
        end else if (resp_take && resp_ok) begin
            report = CODE_OK;                                                // see R12
        end else if (fail_evt) begin
            report = (op_state == OP_ACTIVE) ? CODE_FAIL : CODE_UNAVAIL;     // see R14
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link_code <= CODE_UNAVAIL;
        end else if (ce) begin
            link_code <= report;
        end
    end

    // Status write-out to the application variable on every change while enabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_wr    <= 1'b0;
            stat_value <= CODE_UNAVAIL;
        end else if (ce) begin
            stat_wr <= 1'b0;
            if (report_en && (report != stat_value || report != link_code)) begin
                stat_wr    <= 1'b1;                                          // see R09
                stat_value <= report;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    echo_query_a: assert property (req_valid && req_kind == KIND_ECHO |->  // see R06
        req_func == 8'h08 && req_word == 16'h0000) else $error("echo ping code wrong");
    reg_ping_a: assert property (req_valid && req_kind == KIND_READ |->    // see R07
        req_func == 8'h03 && req_word == ping_reg) else $error("register ping wrong");
    station_id_a: assert property (req_valid |-> req_station == $past(eff_id) &&  // see R01
        (!$past(cfg[`SUP_CFG_ETH_BIT]) || req_station != 8'h00)) else $error("station identity wrong");
    bad_ctrl_a: assert property (cfg[13] && ctrl > 16'h0002 |->            // see R11
        op_state == OP_INACTIVE) else $error("invalid control not inactive");
    no_ctrl_a: assert property (!cfg[13] |-> op_state == OP_ACTIVE)        // see R08
        else $error("uncontrolled slave not active");
    gap_wait_a: assert property (ce && fsm == ST_SEND |->                  // see R04
        $past(fsm) == ST_GAP && $past(ms_cnt) == 16'h0000) else $error("send before gap");
    fail_code_a: assert property (ce && fail_evt && !master_fault &&       // see R14
        op_state == OP_ACTIVE |=> link_code == CODE_FAIL) else $error("missing code 2");
    exc_code_a: assert property (ce && resp_take && resp_exc && !master_fault && // see R15
        op_state != OP_INACTIVE |=> link_code == CODE_SLVERR) else $error("missing code 3");
    fault_code_a: assert property (ce && master_fault |=> link_code == CODE_UNAVAIL) // see R13
        else $error("fault not reported");
    retry_count_a: assert property (fail_evt |-> timeout &&                // see R03
        attempts == max_tries - 4'h1) else $error("failure before retries used");
    tmo_wait_a: assert property (ce && fsm == ST_SEND && op_state != OP_INACTIVE && // see R16
        !master_fault |=> fsm == ST_WAIT && ms_cnt == TMO_MS - 16'h0001) else $error("timeout not loaded");
    report_en_a: assert property (stat_wr |-> $past(report_en))           // see R09
        else $error("status written while disabled");

    fail_seen_c: cover property (fail_evt);
    echo_sent_c: cover property (req_valid && req_kind == KIND_ECHO);
    read_sent_c: cover property (req_valid && req_kind == KIND_READ);
    slv_err_c: cover property (link_code == CODE_SLVERR);
endmodule // modbus_slave_link_supervisor

// ### tb/link_partner.sv
// Behavioural link engine standing for the Modbus slaves on the far side
`timescale 1ns/1ps
module link_partner (
    input  wire logic        clk,
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_kind,
    input  wire logic [7:0]  req_func,
    input  wire logic [15:0] req_word,
    input  wire logic [1:0]  mode,
    output logic             resp_valid = 1'b0,
    output logic             resp_ok = 1'b0,
    output logic             resp_exc = 1'b0
);
    int         wait_cnt = 0;
    logic       good = 1'b0;
    logic [1:0] mode_r = 2'h0;
    logic       fire;

    // Mode 0 answers well, 1 with an exception, 2 never (a dead slave)
    assign fire = wait_cnt == 1 && req_valid !== 1'b1;

    // Reply 1..8 cycles late; idle reply lines toggle so stale values never pass
    always @(posedge clk) begin
        resp_valid <= fire;
        resp_ok    <= fire ? (mode_r == 2'h0 && good) : ~resp_ok;
        resp_exc   <= fire ? (mode_r == 2'h1) : ~resp_exc;
        if (req_valid === 1'b1) begin
            wait_cnt <= (mode == 2'h2) ? 0 : int'($urandom_range(8, 1));
            mode_r   <= mode;
            good     <= req_kind != 2'h0 || (req_func == 8'h08 && req_word == 16'h0000);
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule // link_partner

// ### tb/tb_top.sv
// Self-checking bench for the per-slave link supervisor
`timescale 1ns/1ps
`include "link_sup_params.svh"
module tb_top;
    import link_sup_pkg::*;
    logic        clk = 0, resetn = 0, ce = 1, cyc = 0, stb = 0, we = 0, fault = 0, exp_on = 0;
    logic        ack, req_valid, resp_valid, resp_ok, resp_exc, stat_wr, irq;
    logic [1:0]  mode = 0;
    logic [3:0]  sel = 4'h3;
    logic [7:0]  adr = 0, id, req_station, req_func;
    logic [15:0] preg, req_word, base;
    logic [31:0] wdat = 0, rdat, dat_o;
    logic [33:0] exp_req = 0;
    kind_e       req_kind;
    code_e       stat_value;
    int          fail_count = 0, checked = 0, cyc_n = 0, n_req = 0, n_wr = 0, n0, exp_gap = 0, last = 0;
    logic [23:0] rst_tab [7] = '{{`SUP_CFG_OFF, `SUP_CFG_RST}, {`SUP_GAP_OFF, `SUP_GAP_RST},
        {`SUP_PING_INT_OFF, `SUP_PING_INT_RST}, {`SUP_PING_REG_OFF, `SUP_PING_REG_RST},
        {`SUP_CTRL_OFF, `SUP_CTRL_RST}, {`SUP_IRQ_MASK_OFF, 16'h0}, {8'h20, 16'h0}};

    // Short millisecond and timeout so the run stays brief
    modbus_slave_link_supervisor #(.MS_CYCLES(10), .TIMEOUT_MS(2)) modbus_slave_link_supervisor_i (
        .clk(clk), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .req_valid(req_valid), .req_kind(req_kind), .req_station(req_station), .req_func(req_func),
        .req_word(req_word), .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_exc(resp_exc),
        .master_fault(fault), .stat_wr(stat_wr), .stat_value(stat_value), .irq(irq));
    link_partner link_partner_i (
        .clk(clk), .req_valid(req_valid), .req_kind(req_kind), .req_func(req_func),
        .req_word(req_word), .mode(mode), .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_exc(resp_exc));

    // 10 MHz clock
    initial forever #50 clk = ~clk;

    // Hang guard, several times the expected run
    initial begin
        #(100 * 60000);
        fail_count++;
        report_and_stop();
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Classic single cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1;
        stb  <= 1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 0;
        stb <= 0;
    endtask

    task automatic wait_req(input int n);
        int t;
        t = n_req + n;
        for (int i = 0; i < 4000 && n_req < t; i++) @(posedge clk);
        check(n_req >= t, 1);
    endtask

    // Waits for the expected code, then also reads it back over the bus
    task automatic expect_code(input code_e e);
        for (int i = 0; i < 4000 && stat_value !== e; i++) @(posedge clk);
        check(stat_value, e);
        wb(0, `SUP_STAT_OFF, 0);
        check(rdat[1:0], e);
    endtask

    // New settings; the first request after them may still be of the old kind
    task automatic set_mode(input logic [15:0] cfg, input logic [15:0] ctrl, input logic [33:0] r, input int g);
        exp_on <= 0;
        wb(1, `SUP_CFG_OFF, cfg);
        wb(1, `SUP_CTRL_OFF, ctrl);
        wait_req(1);
        exp_req <= r;
        exp_gap <= g;
        exp_on  <= 1;
    endtask

    // Reference model of each request's fields and spacing
    always @(posedge clk) begin
        cyc_n++;
        if (stat_wr === 1'b1) n_wr++;
        if (req_valid === 1'b1) begin
            n_req++;
            if (exp_on) check({req_kind, req_station, req_func}, exp_req[33:16]);
            if (exp_on && req_kind != KIND_POLL) check(req_word, exp_req[15:0]);
            if (exp_on) check(cyc_n - last >= exp_gap, 1);
            last = cyc_n;
        end
    end

    initial begin
        void'($urandom(81061));
        id   = 8'($urandom_range(254, 2));
        preg = 16'($urandom);
        base = 16'h6200 | {8'h00, id};
        repeat (12) @(posedge clk);
        check({stat_value, req_valid, ack, irq, stat_wr}, 6'h10);
        resetn <= 1;
        wb(1, 8'h20, 32'h0000_ffff);
        foreach (rst_tab[i]) begin
            wb(0, rst_tab[i][23:16], 0);
            check(rdat, rst_tab[i][15:0]);
        end
        wb(1, `SUP_GAP_OFF, 1);
        wb(1, `SUP_PING_INT_OFF, 2);
        wb(1, `SUP_PING_REG_OFF, preg);
        wb(1, `SUP_IRQ_MASK_OFF, 1);
        // Echo pings in standby, then polling answered with exceptions
        set_mode(base, 1, {KIND_ECHO, id, `SUP_FN_ECHO, `SUP_FN_ECHO_SUB}, 20);
        expect_code(CODE_OK);
        n0 = n_wr;
        mode <= 1;
        set_mode(base, 2, {KIND_POLL, id, 24'h0}, 10);
        expect_code(CODE_SLVERR);
        check(n_wr > n0, 1);
        // Dead slave while polling: two timed-out attempts before failure
        wait_req(1);
        mode <= 2;
        n0 = n_req;
        expect_code(CODE_FAIL);
        check(n_req - n0, 2);
        check(irq, 1);
        // Unknown control code and then zero both keep the slave quiet
        wb(1, `SUP_CTRL_OFF, 3);
        expect_code(CODE_OK);
        wb(0, `SUP_IRQ_ST_OFF, 0);
        check(rdat[0], 1);
        check(irq, 0);
        for (int c = 3; c >= 0; c -= 3) begin
            wb(1, `SUP_CTRL_OFF, c);
            n0 = n_req;
            repeat (300) @(posedge clk);
            check(n_req - n0, 0);
        end
        // Clock enable low freezes the sequencer: no request and no status change while frozen
        wb(1, `SUP_CTRL_OFF, 2);
        ce <= 0;
        n0 = n_req;
        repeat (200) @(posedge clk);
        check(n_req - n0, 0);
        check(stat_value, CODE_OK);
        ce <= 1;
        set_mode(base, 1, {KIND_ECHO, id, `SUP_FN_ECHO, `SUP_FN_ECHO_SUB}, 20);
        expect_code(CODE_UNAVAIL);
        // Register pings, then a master fault
        mode <= 0;
        set_mode(base | 16'h1000, 1, {KIND_READ, id, `SUP_FN_READ, preg}, 20);
        expect_code(CODE_OK);
        fault <= 1;
        expect_code(CODE_UNAVAIL);
        fault <= 0;
        expect_code(CODE_OK);
        // Ethernet with identity 0, then control and reporting disabled
        set_mode(16'he200, 2, {KIND_POLL, `SUP_ETH_ID, 24'h0}, 10);
        wait_req(2);
        set_mode(16'h0200 | {8'h00, id}, 0, {KIND_POLL, id, 24'h0}, 10);
        wait_req(2);
        n0 = n_wr;
        mode <= 2;
        // Reporting is off, so the failure is only visible in the status register
        for (int i = 0; i < 400 && rdat[1:0] !== CODE_FAIL; i++) wb(0, `SUP_STAT_OFF, 0);
        check(rdat[1:0], CODE_FAIL);
        check(stat_value, CODE_OK);
        check(n_wr - n0, 0);
        report_and_stop();
    end
endmodule // tb_top
